// file: rtl/pps_pkg.sv
package pps_pkg;

  // ----------------------------------------------------------------------
  // Rails, slots and field layouts
  // ----------------------------------------------------------------------
  localparam int unsigned NUM_RAILS = 8;
  localparam int unsigned SLOT_W = 4;
  localparam int unsigned IVL_W = 6;
  // Rail order in every rail vector, bit index
  localparam int unsigned RAIL_BUCK1 = 7;
  localparam int unsigned RAIL_BUCK2 = 6;
  localparam int unsigned RAIL_BUCK3 = 5;
  localparam int unsigned RAIL_BUCK4 = 4;
  localparam int unsigned RAIL_LDO2 = 3;
  localparam int unsigned RAIL_LOAD_SWITCH_RAIL = 2;
  localparam int unsigned RAIL_LDOB = 1;
  localparam int unsigned RAIL_LDOC = 0;
  // Delayed shutdown starts from this interval
  localparam logic [5:0] DELAY_START_IVL = 6'h3C;
  localparam logic [3:0] SLOT_ZERO = 4'h0;
  localparam logic [5:0] IVL_ZERO = 6'h00;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic RST_DELAY_EN = 1'h0;
  localparam logic RST_STYLE = 1'h0;
  localparam logic RST_DISCHG = 1'h1;
  localparam logic [4:0] RST_ADDR = 5'h09;
  localparam logic RST_ILIM = 1'h0;
  localparam logic RST_PAIR = 1'h0;
  localparam logic RST_KEY_MODE = 1'h0;
  localparam logic RST_AUX_ON = 1'h0;
  localparam logic RST_AUX_POL = 1'h1;
  localparam logic RST_AUX_SEL = 1'h0;
  localparam logic [6:0] RST_AUX_MASK = 7'h07;
  localparam logic [31:0] RST_SLOTS = 32'h3231_04AB;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned DEBOUNCE_US = 50;
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned IVL_US = 500;
  localparam int unsigned IVL_CYC = IVL_US * (CLK_HZ / 1_000_000);

  // ----------------------------------------------------------------------
  // Carrier for the configuration fields
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic shutdown_delay_enable;
    logic shutdown_style_select;
    logic switch_discharge_enable;
    logic [4:0] bus_target_address_bits;
    logic ldo_current_limit_select;
    logic buck_pair_a_parallel;
    logic buck_pair_b_parallel;
    logic power_key_trigger_mode;
    logic aux_enable_function_on;
    logic aux_enable_polarity;
    logic aux_enable_pin_select;
    logic [6:0] aux_enable_rail_mask;
    logic [31:0] rail_off_slot_number;
  } pps_cfg_t;

  localparam int unsigned CFG_W = $bits(pps_cfg_t);

  typedef enum logic [1:0] {
    ST_OFF,
    ST_ON,
    ST_SEQ_OFF
  } pps_state_t;

endpackage : pps_pkg

// file: rtl/pps_power_sequence_control.sv
`timescale 1ns/1ns
// Functional notes
// - Delay bit counts only with style zero
// - No delay: start at highest enabled slot
// - Delay: count down from interval sixty
// - Key shutdown: style picks ordered or instant
// - Aux pin shutdown is always ordered
// - Discharge bit drives switch discharge, resets one
// - Five address bits, reset 01001
// - Current limit bit selects 300 or 550mA
// - Pair A parallels buck1/3, buck3 ignored
// - Pair B parallels buck2/4, buck4 ignored
// - Pair bits sampled only at supply start
// - Level mode: high key starts up
// - Edge mode: debounced fall toggles on/off
// - Aux function bit gates pin over mask
// - Aux polarity bit picks active level
// - Select picks switch or LDO2 pin
// - Seven-bit rail mask, reset 0000111
// - Four-bit off slot per rail
module pps_power_sequence_control #(
  parameter int unsigned DEBOUNCE_CYCLES = pps_pkg::DEBOUNCE_CYC,
  parameter int unsigned INTERVAL_CYCLES = pps_pkg::IVL_CYC
) (
  // Clock and reset (reset = start-up from the input supply)
  input wire logic clk_sys_in,
  input wire logic srst_in,
  // Configuration write port, whole image loaded at once
  input wire logic cfg_wr_in,
  input wire pps_pkg::pps_cfg_t cfg_in,
  // Pins from outside
  input wire logic power_key_pin_in,
  input wire logic switch_output_pin_in,
  input wire logic ldo2_pin_in,
  // Host rail enables
  input wire logic [7:0] rail_enable_in,
  // Status and rail control
  output pps_pkg::pps_cfg_t cfg_out,
  output logic [7:0] rail_on_out,
  output logic switch_discharge_out,
  output logic ldo_b_current_limit_select_out,
  output logic ldo_c_current_limit_select_out,
  output logic [4:0] bus_target_address_out,
  output logic buck_pair_a_out,
  output logic buck_pair_b_out,
  output logic powered_out
);

  // --------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------
  pps_pkg::pps_cfg_t cfg;
  pps_pkg::pps_cfg_t rst_cfg;
  pps_pkg::pps_cfg_t next_cfg;
  logic pair_a;
  logic pair_b;

  assign rst_cfg = '{
    shutdown_delay_enable: pps_pkg::RST_DELAY_EN,
    shutdown_style_select: pps_pkg::RST_STYLE,
    switch_discharge_enable: pps_pkg::RST_DISCHG,
    bus_target_address_bits: pps_pkg::RST_ADDR,
    ldo_current_limit_select: pps_pkg::RST_ILIM,
    buck_pair_a_parallel: pps_pkg::RST_PAIR,
    buck_pair_b_parallel: pps_pkg::RST_PAIR,
    power_key_trigger_mode: pps_pkg::RST_KEY_MODE,
    aux_enable_function_on: pps_pkg::RST_AUX_ON,
    aux_enable_polarity: pps_pkg::RST_AUX_POL,
    aux_enable_pin_select: pps_pkg::RST_AUX_SEL,
    aux_enable_rail_mask: pps_pkg::RST_AUX_MASK,
    rail_off_slot_number: pps_pkg::RST_SLOTS
  };
  assign next_cfg = cfg_wr_in ? cfg_in : cfg;

  // Supply start restores defaults
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      cfg <= rst_cfg;
    end else begin
      cfg <= next_cfg;
    end
  end

  // Pairing is latched on the first cycle after supply start only; later
  // writes land in the register image but never reach the converters
  logic pair_armed;
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      pair_armed <= 1'b1;
      pair_a <= pps_pkg::RST_PAIR;
      pair_b <= pps_pkg::RST_PAIR;
    end else if (pair_armed) begin
      pair_armed <= 1'b0;
      pair_a <= cfg.buck_pair_a_parallel;
      pair_b <= cfg.buck_pair_b_parallel;
    end
  end

  // --------------------------------------------------------------------
  // Pin synchronisers: change counts once stages two and three agree
  // --------------------------------------------------------------------
  logic [2:0] key_sync;
  logic [2:0] sw_sync;
  logic [2:0] l2_sync;
  logic key_lvl;
  logic sw_lvl;
  logic l2_lvl;
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      key_sync <= 3'h0;
      sw_sync <= 3'h0;
      l2_sync <= 3'h0;
      key_lvl <= 1'b0;
      sw_lvl <= 1'b0;
      l2_lvl <= 1'b0;
    end else begin
      key_sync <= {key_sync[1:0], power_key_pin_in};
      sw_sync <= {sw_sync[1:0], switch_output_pin_in};
      l2_sync <= {l2_sync[1:0], ldo2_pin_in};
      if (key_sync[1] == key_sync[2]) key_lvl <= key_sync[2];
      if (sw_sync[1] == sw_sync[2]) sw_lvl <= sw_sync[2];
      if (l2_sync[1] == l2_sync[2]) l2_lvl <= l2_sync[2];
    end
  end

  // --------------------------------------------------------------------
  // Power key: falling edge, then debounce wait
  // --------------------------------------------------------------------
  logic key_prev;
  logic [31:0] deb_cnt;
  logic deb_busy;
  logic key_fall;
  logic key_toggle;
  assign key_fall = key_prev & ~key_lvl;
  assign key_toggle = deb_busy && deb_cnt == 32'h0000_0001;
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      key_prev <= 1'b0;
      deb_cnt <= 32'h0;
      deb_busy <= 1'b0;
    end else begin
      key_prev <= key_lvl;
      if (key_fall && !deb_busy && cfg.power_key_trigger_mode) begin
        deb_busy <= 1'b1;
        deb_cnt <= DEBOUNCE_CYCLES;
      end else if (deb_busy) begin
        deb_cnt <= deb_cnt - 32'h1;
        if (deb_cnt == 32'h0000_0001) deb_busy <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Aux enable pin decode
  // --------------------------------------------------------------------
  logic aux_raw;
  logic aux_active;
  logic [7:0] aux_mask8;
  assign aux_raw = cfg.aux_enable_pin_select ? l2_lvl : sw_lvl;
  // Pin level equal to polarity means rails on
  assign aux_active = ~(aux_raw ^ cfg.aux_enable_polarity);
  // LDO2 never follows the aux pin, so its mask bit is zero
  assign aux_mask8 = cfg.aux_enable_function_on ?
    {cfg.aux_enable_rail_mask[6:3], 1'b0, cfg.aux_enable_rail_mask[2:0]}
    : 8'h00;

  // --------------------------------------------------------------------
  // Key-driven state machine and interval ticker
  // --------------------------------------------------------------------
  pps_pkg::pps_state_t state;
  pps_pkg::pps_state_t next_state;
  logic [31:0] tick_cnt;
  logic tick;
  logic [5:0] ivl;
  logic [5:0] start_ivl;
  logic [5:0] max_slot;
  logic [7:0] eff_en;
  logic key_on_req;
  logic key_off_req;
  logic aux_was_active;
  logic aux_off_start;
  logic [7:0] aux_seq;
  logic [7:0] next_rail;
  logic [7:0] off_due;
  logic instant_off;
  logic use_delay;

  // Buck 3 and 4 follow their partner when paired
  assign eff_en = {rail_enable_in[7:6],
    pair_a ? rail_enable_in[7] : rail_enable_in[5],
    pair_b ? rail_enable_in[6] : rail_enable_in[4],
    rail_enable_in[3:0]};

  assign tick = tick_cnt == 32'h0;
  assign key_on_req = cfg.power_key_trigger_mode ? key_toggle
    : key_lvl;
  assign key_off_req = cfg.power_key_trigger_mode ? key_toggle : ~key_lvl;
  // Delay bit honoured only under ordered style
  assign use_delay = cfg.shutdown_delay_enable &
    ~cfg.shutdown_style_select;
  assign instant_off = cfg.shutdown_style_select;
  assign start_ivl = use_delay ? pps_pkg::DELAY_START_IVL : max_slot;
  assign aux_off_start = aux_was_active & ~aux_active & |aux_mask8;

  // Highest off slot among enabled rails
  always_comb begin
    max_slot = pps_pkg::IVL_ZERO;
    for (int i = 0; i < 8; i++) begin
      if (eff_en[i] && {2'b00, cfg.rail_off_slot_number[i*4 +: 4]} >
          max_slot) begin
        max_slot = {2'b00, cfg.rail_off_slot_number[i*4 +: 4]};
      end
    end
  end

  // Rails whose own slot is at or above the running interval
  always_comb begin
    off_due = 8'h00;
    for (int i = 0; i < 8; i++) begin
      off_due[i] = {2'b00, cfg.rail_off_slot_number[i*4 +: 4]} >= ivl;
    end
  end

  always_comb begin
    next_state = state;
    next_rail = rail_on_out;
    case (state)
      pps_pkg::ST_OFF: begin
        if (key_on_req) begin
          next_state = pps_pkg::ST_ON;
          next_rail = eff_en;
        end
      end
      pps_pkg::ST_ON: begin
        next_rail = eff_en & (~aux_mask8 | {8{aux_active}});
        if (key_off_req) begin
          if (instant_off) begin
            next_state = pps_pkg::ST_OFF;
            next_rail = 8'h00;
          end else begin
            next_state = pps_pkg::ST_SEQ_OFF;
          end
        end else if (aux_off_start) begin
          // Aux shutdown stays ordered whatever the style bit
          next_rail = rail_on_out;
        end else if (aux_seq != 8'h00 && tick) begin
          next_rail = rail_on_out & ~(aux_seq & off_due);
        end else if (aux_seq != 8'h00) begin
          next_rail = rail_on_out;
        end
      end
      pps_pkg::ST_SEQ_OFF: begin
        if (tick) begin
          next_rail = rail_on_out & ~off_due;
          if (ivl == pps_pkg::IVL_ZERO) begin
            next_state = pps_pkg::ST_OFF;
            next_rail = 8'h00;
          end
        end
      end
      default: begin
        next_state = pps_pkg::ST_OFF;
        next_rail = 8'h00;
      end
    endcase
  end

  // Interval counter, shared by key and aux shutdowns
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      state <= pps_pkg::ST_OFF;
      rail_on_out <= 8'h00;
      tick_cnt <= 32'h0;
      ivl <= pps_pkg::IVL_ZERO;
      aux_was_active <= 1'b0;
      aux_seq <= 8'h00;
    end else begin
      state <= next_state;
      rail_on_out <= next_rail;
      aux_was_active <= aux_active;
      tick_cnt <= tick ? INTERVAL_CYCLES - 32'h1 : tick_cnt - 32'h1;
      if ((state == pps_pkg::ST_ON && key_off_req && !instant_off) ||
          (state == pps_pkg::ST_ON && aux_off_start)) begin
        ivl <= start_ivl;
        tick_cnt <= INTERVAL_CYCLES - 32'h1;
      end else if (tick && ivl != pps_pkg::IVL_ZERO) begin
        ivl <= ivl - 6'h01;
      end
      if (state == pps_pkg::ST_ON && aux_off_start) begin
        aux_seq <= aux_mask8 & rail_on_out;
      end else if (aux_active || state != pps_pkg::ST_ON ||
                   (tick && ivl == pps_pkg::IVL_ZERO)) begin
        aux_seq <= 8'h00;
      end
    end
  end

  // --------------------------------------------------------------------
  // Registered configuration outputs
  // --------------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      cfg_out <= rst_cfg;
      switch_discharge_out <= pps_pkg::RST_DISCHG;
      ldo_b_current_limit_select_out <= pps_pkg::RST_ILIM;
      ldo_c_current_limit_select_out <= pps_pkg::RST_ILIM;
      bus_target_address_out <= pps_pkg::RST_ADDR;
      buck_pair_a_out <= pps_pkg::RST_PAIR;
      buck_pair_b_out <= pps_pkg::RST_PAIR;
      powered_out <= 1'b0;
    end else begin
      cfg_out <= cfg;
      switch_discharge_out <= cfg.switch_discharge_enable;
      ldo_b_current_limit_select_out <= cfg.ldo_current_limit_select;
      ldo_c_current_limit_select_out <= cfg.ldo_current_limit_select;
      bus_target_address_out <= cfg.bus_target_address_bits;
      buck_pair_a_out <= pair_a;
      buck_pair_b_out <= pair_b;
      powered_out <= state != pps_pkg::ST_OFF;
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  property p_instant_off;
    @(posedge clk_sys_in) disable iff (srst_in)
    (state == pps_pkg::ST_ON && key_off_req && instant_off) |=>
      (rail_on_out == 8'h00);
  endproperty
  a_instant_off: assert property (p_instant_off)
    else $error("instant shutdown left a rail on");

  property p_delay_start;
    @(posedge clk_sys_in) disable iff (srst_in)
    (state == pps_pkg::ST_ON && key_off_req && !instant_off && use_delay)
      |=> (ivl == pps_pkg::DELAY_START_IVL);
  endproperty
  a_delay_start: assert property (p_delay_start)
    else $error("delayed shutdown did not start at interval sixty");

  property p_style_kills_delay;
    @(posedge clk_sys_in) disable iff (srst_in)
    cfg.shutdown_style_select |-> !use_delay;
  endproperty
  a_style_kills_delay: assert property (p_style_kills_delay)
    else $error("delay active under instant style");

  property p_pair_hold;
    @(posedge clk_sys_in) disable iff (srst_in)
    !pair_armed |=> $stable(pair_a) && $stable(pair_b);
  endproperty
  a_pair_hold: assert property (p_pair_hold)
    else $error("pairing changed after start-up");

  property p_aux_off;
    @(posedge clk_sys_in) disable iff (srst_in)
    !cfg.aux_enable_function_on |-> aux_mask8 == 8'h00;
  endproperty
  a_aux_off: assert property (p_aux_off)
    else $error("aux pin acts while disabled");

  property p_level_on;
    @(posedge clk_sys_in) disable iff (srst_in)
    (state == pps_pkg::ST_OFF && !cfg.power_key_trigger_mode && key_lvl)
      |=> powered_out == 1'b0 ##1 powered_out;
  endproperty
  a_level_on: assert property (p_level_on)
    else $error("level key did not start up");

  property p_debounce;
    @(posedge clk_sys_in) disable iff (srst_in)
    $rose(deb_busy) |-> !key_toggle;
  endproperty
  a_debounce: assert property (p_debounce)
    else $error("key acted before debounce");

  property p_discharge;
    @(posedge clk_sys_in) disable iff (srst_in)
    1'b1 |=> switch_discharge_out == $past(cfg.switch_discharge_enable);
  endproperty
  a_discharge: assert property (p_discharge)
    else $error("discharge output does not follow its bit");

endmodule : pps_power_sequence_control

// file: test/pps_host_model.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------------
// Host side: key pin, aux candidate pins and rail enables
// ----------------------------------------------------------------------
module pps_host_model (
  // Clock
  input wire logic clk_sys_in,
  // Pins and enables into the block
  output logic power_key_pin_out,
  output logic switch_output_pin_out,
  output logic ldo2_pin_out,
  output logic [7:0] rail_enable_out
);
  // Quiet start: key released, aux pins high, every rail disabled
  initial begin
    power_key_pin_out = 1'h0;
    switch_output_pin_out = 1'h1;
    ldo2_pin_out = 1'h1;
    rail_enable_out = 8'h00;
  end

  // Key level changes land just after a rising edge
  task automatic set_key(input logic v);
    @(posedge clk_sys_in);
    power_key_pin_out <= v;
  endtask : set_key

  // Both aux candidate pins move together
  task automatic set_aux(input logic sw, input logic ldo2);
    @(posedge clk_sys_in);
    switch_output_pin_out <= sw;
    ldo2_pin_out <= ldo2;
  endtask : set_aux

  // Switch and LDO2 rails stay off so either pin may act as aux input
  task automatic set_enables(input logic [7:0] e);
    @(posedge clk_sys_in);
    rail_enable_out <= e & 8'hF3;
  endtask : set_enables
endmodule : pps_host_model

// file: test/pps_power_sequence_control_tb.sv
`timescale 1ns/1ns
module pps_power_sequence_control_tb;
  // ----------------------------------------------------------------------
  // Bench signals
  // ----------------------------------------------------------------------
  logic clk_sys_in;
  logic srst_in;
  logic cfg_wr_in;
  pps_pkg::pps_cfg_t cfg_in;
  pps_pkg::pps_cfg_t cfg_out;
  pps_pkg::pps_cfg_t c;
  wire logic key_w;
  wire logic sw_pin_w;
  wire logic ldo2_pin_w;
  wire logic [7:0] ena_w;
  logic [7:0] rail_on_out;
  logic switch_discharge_out;
  logic ldo_b_out;
  logic ldo_c_out;
  logic [4:0] addr_out;
  logic pair_a_out;
  logic pair_b_out;
  logic powered_out;
  wire logic [8:0] mon_w;
  int errors = 0;
  int checked = 0;
  int cycles = 0;
  // Short counts keep sequences to a few hundred cycles
  localparam int unsigned DEB = 4;
  localparam int unsigned IVL = 8;
  assign mon_w = {powered_out, rail_on_out};

  pps_host_model host_u (
    .clk_sys_in(clk_sys_in), .power_key_pin_out(key_w),
    .switch_output_pin_out(sw_pin_w), .ldo2_pin_out(ldo2_pin_w),
    .rail_enable_out(ena_w));

  pps_power_sequence_control #(.DEBOUNCE_CYCLES(DEB),
    .INTERVAL_CYCLES(IVL)) dut_u (
    .clk_sys_in(clk_sys_in), .srst_in(srst_in), .cfg_wr_in(cfg_wr_in),
    .cfg_in(cfg_in), .power_key_pin_in(key_w),
    .switch_output_pin_in(sw_pin_w), .ldo2_pin_in(ldo2_pin_w),
    .rail_enable_in(ena_w), .cfg_out(cfg_out), .rail_on_out(rail_on_out),
    .switch_discharge_out(switch_discharge_out),
    .ldo_b_current_limit_select_out(ldo_b_out),
    .ldo_c_current_limit_select_out(ldo_c_out),
    .bus_target_address_out(addr_out), .buck_pair_a_out(pair_a_out),
    .buck_pair_b_out(pair_b_out), .powered_out(powered_out));

  // ----------------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------------
  initial begin
    clk_sys_in = 1'h0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end
  // Whole run needs well under this; a stuck wait lands here
  always @(posedge clk_sys_in) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      test_done();
    end
  end

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic test_done();
    if (errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string name, input logic [63:0] seen,
                     input logic [63:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask : step

  // Bounded wait on one rail bit, or bit 8 for the powered flag
  task automatic wait_mon(input int idx, input logic val, input int lim);
    int n;
    n = 0;
    while (mon_w[idx] !== val && n < lim) begin
      step(1);
      n = n + 1;
    end
    chk("rail_or_powered", mon_w[idx], val);
  endtask : wait_mon

  function automatic pps_pkg::pps_cfg_t dflt();
    pps_pkg::pps_cfg_t d;
    d = '0;
    d.switch_discharge_enable = 1'h1;
    d.bus_target_address_bits = 5'h09;
    d.aux_enable_polarity = 1'h1;
    d.aux_enable_rail_mask = 7'h07;
    d.rail_off_slot_number = 32'h3231_04AB;
    return d;
  endfunction : dflt

  // Image goes in at one edge, output settles two edges later
  task automatic write_cfg(input pps_pkg::pps_cfg_t v);
    @(posedge clk_sys_in);
    cfg_in <= v;
    cfg_wr_in <= 1'h1;
    @(posedge clk_sys_in);
    cfg_wr_in <= 1'h0;
    step(2);
  endtask : write_cfg

  task automatic key_to(input logic v, input int lim);
    host_u.set_key(v);
    wait_mon(8, v, lim);
  endtask : key_to

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_defaults();
    chk("cfg_out", cfg_out, dflt());
    chk("discharge", switch_discharge_out, 1'h1);
    chk("address", addr_out, 5'h09);
    chk("ilim", {ldo_b_out, ldo_c_out}, 2'h0);
    chk("rails", mon_w, 9'h000);
  endtask : t_defaults

  // Pairing writes after start-up are ignored; a new start-up clears all
  task automatic t_fields();
    c = dflt();
    c.ldo_current_limit_select = 1'h1;
    c.switch_discharge_enable = 1'h0;
    c.bus_target_address_bits = 5'h16;
    c.buck_pair_a_parallel = 1'h1;
    c.buck_pair_b_parallel = 1'h1;
    write_cfg(c);
    chk("ilim", {ldo_b_out, ldo_c_out}, 2'h3);
    chk("discharge", switch_discharge_out, 1'h0);
    chk("address", addr_out, 5'h16);
    chk("pairs", {pair_a_out, pair_b_out}, 2'h0);
    @(posedge clk_sys_in);
    srst_in <= 1'h1;
    repeat (2) @(posedge clk_sys_in);
    srst_in <= 1'h0;
    step(1);
    t_defaults();
    chk("pairs", {pair_a_out, pair_b_out}, 2'h0);
  endtask : t_fields

  // Style one: delay bit has no say, everything drops together
  task automatic t_instant();
    c = dflt();
    c.shutdown_style_select = 1'h1;
    c.shutdown_delay_enable = 1'h1;
    write_cfg(c);
    host_u.set_enables(8'hF0);
    key_to(1'h1, 20);
    chk("rails", rail_on_out, 8'hF0);
    host_u.set_key(1'h0);
    wait_mon(7, 1'h0, 20);
    chk("rails", rail_on_out, 8'h00);
    wait_mon(8, 1'h0, 5);
  endtask : t_instant

  // Slots: buck1/3 at 3, buck2 at 2, buck4 at 1
  task automatic t_ordered(input logic dly);
    c = dflt();
    c.shutdown_delay_enable = dly;
    write_cfg(c);
    key_to(1'h1, 20);
    host_u.set_key(1'h0);
    if (dly) begin
      step(40 * IVL);
      chk("rails_held", rail_on_out, 8'hF0);
    end
    wait_mon(7, 1'h0, dly ? 40 * IVL : 60);
    chk("rails", rail_on_out, 8'h50);
    wait_mon(6, 1'h0, 3 * IVL);
    chk("buck4", rail_on_out[4], 1'h1);
    wait_mon(8, 1'h0, 6 * IVL);
  endtask : t_ordered

  // Edge mode: highs do nothing, each debounced fall toggles
  task automatic t_edge();
    c = dflt();
    c.power_key_trigger_mode = 1'h1;
    c.shutdown_style_select = 1'h1;
    write_cfg(c);
    host_u.set_key(1'h1);
    step(12);
    chk("powered", powered_out, 1'h0);
    host_u.set_key(1'h0);
    step(2);
    chk("powered", powered_out, 1'h0);
    wait_mon(8, 1'h1, 30);
    host_u.set_key(1'h1);
    step(12);
    key_to(1'h0, 30);
  endtask : t_edge

  // Aux pin on LDO2 leg, mask buck1/buck2, style one still ordered
  task automatic t_aux();
    c = dflt();
    c.shutdown_style_select = 1'h1;
    c.switch_discharge_enable = 1'h0;
    c.aux_enable_function_on = 1'h1;
    c.aux_enable_pin_select = 1'h1;
    c.aux_enable_rail_mask = 7'h60;
    write_cfg(c);
    key_to(1'h1, 20);
    host_u.set_aux(1'h0, 1'h1);
    step(20);
    chk("rails", rail_on_out, 8'hF0);
    host_u.set_aux(1'h0, 1'h0);
    wait_mon(7, 1'h0, 60);
    chk("rails", rail_on_out, 8'h70);
    key_to(1'h0, 10);
    // Polarity zero on the switch leg: rising to high starts the drop
    c.aux_enable_polarity = 1'h0;
    c.aux_enable_pin_select = 1'h0;
    write_cfg(c);
    key_to(1'h1, 20);
    host_u.set_aux(1'h1, 1'h0);
    wait_mon(7, 1'h0, 60);
    chk("rails", rail_on_out, 8'h70);
    key_to(1'h0, 10);
    // Function off: an active-to-idle change on the pin does nothing
    c.aux_enable_function_on = 1'h0;
    write_cfg(c);
    host_u.set_aux(1'h0, 1'h0);
    key_to(1'h1, 20);
    host_u.set_aux(1'h1, 1'h0);
    step(60);
    chk("rails", rail_on_out, 8'hF0);
    key_to(1'h0, 10);
  endtask : t_aux

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    srst_in = 1'h1;
    cfg_wr_in = 1'h0;
    cfg_in = dflt();
    repeat (2) @(posedge clk_sys_in);
    srst_in <= 1'h0;
    step(1);
    t_defaults();
    t_fields();
    t_instant();
    t_ordered(1'h0);
    t_ordered(1'h1);
    t_edge();
    t_aux();
    test_done();
  end
endmodule : pps_power_sequence_control_tb
